// File: design/logic_analyzer_capture.v
`timescale 1ns/1ps
`include "la_capture_defs.vh"
// capture engine: sample, trigger, store, then upload in blocks
module logic_analyzer_capture #(
    parameter ADDR_W = `ADDR_W,
    parameter BAUD_DIV = `BAUD_DIV
) (
    input wire ref_clk,
    input wire rst,
    input wire [17:0] target_in,
    input wire external_sample_clock,
    input wire [15:0] rate_div,
    input wire sync_mode,
    input wire [1:0] trig_pos,
    input wire [53:0] trig_cond,
    input wire run_cmd,
    input wire stop_cmd,
    input wire probe_sel_a,
    input wire probe_sel_b,
    input wire probe_out_a,
    input wire probe_out_b,
    input wire serial_data_out,
    input wire cksum_cmd,
    input wire block_nak,
    output reg [1:0] state_out,
    output reg [17:0] live_level,
    output reg [ADDR_W-1:0] trig_addr,
    output reg [ADDR_W-1:0] progress,
    output reg [15:0] cksum_read,
    output reg cksum_done,
    output reg cksum_clk,
    output reg tx_line
);
    localparam S_IDLE = 2'h0;
    localparam S_PRE = 2'h1;
    localparam S_POSTTRIGGER_STATE = 2'h2;
    localparam S_READ = 2'h3;
    localparam [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};
    localparam [ADDR_W:0] BLK = `BLOCK_LEN;

    // two-flop sync of the target, probe, sample clock and serial data out pins
    reg [17:0] in_m_q, in_s_q;
    reg [1:0] pa_m_q, pa_s_q;
    reg ck_m_q, ck_s_q, ck_p_q, sdo_m_q, sdo_s_q;
    always @(posedge ref_clk) begin
        in_m_q <= target_in;
        in_s_q <= in_m_q;
        pa_m_q <= {probe_out_b, probe_out_a};
        pa_s_q <= pa_m_q;
        ck_m_q <= external_sample_clock;
        ck_s_q <= ck_m_q;
        ck_p_q <= ck_s_q;
        sdo_m_q <= serial_data_out;
        sdo_s_q <= sdo_m_q;
    end

    wire [17:0] chan = {in_s_q[17:2],
        probe_sel_b ? pa_s_q[1] : in_s_q[1],
        probe_sel_a ? pa_s_q[0] : in_s_q[0]};

    // internal rate divider or external clock edge
    reg [15:0] div_q;
    wire tick_int = (div_q == 16'h0000);
    // relies on a running external clock
    wire tick = sync_mode ? (ck_s_q && !ck_p_q) : tick_int;
    always @(posedge ref_clk) begin
        if (rst || tick_int)
            div_q <= rate_div;
        else
            div_q <= div_q - 16'h0001;
    end

    reg [17:0] prev_q;
    reg [17:0] hit;
    integer i;
    always @* begin
        hit = 18'h0;
        for (i = 0; i < 18; i = i + 1) begin
            case (trig_cond[3*i +: 3])
                `TRIG_IGNORE: hit[i] = 1'b1;
                `TRIG_LOW: hit[i] = !chan[i];
                `TRIG_HIGH: hit[i] = chan[i];
                `TRIG_RISE: hit[i] = chan[i] && !prev_q[i];
                `TRIG_FALL: hit[i] = !chan[i] && prev_q[i];
                `TRIG_EDGE: hit[i] = chan[i] ^ prev_q[i];
                default: hit[i] = 1'b1;
            endcase
        end
    end
    wire trig_now = &hit;

    reg [ADDR_W:0] posttrigger_state_len;
    always @* begin
        case (trig_pos)
            `POS_25: posttrigger_state_len = DEPTH - (DEPTH >> 2);
            `POS_75: posttrigger_state_len = DEPTH >> 2;
            default: posttrigger_state_len = DEPTH >> 1;
        endcase
    end

    reg [17:0] mem [0:(1<<ADDR_W)-1];
    reg [ADDR_W-1:0] wa_q;
    reg [ADDR_W:0] cnt_q;
    reg [1:0] st_q;
    reg stop_q;
    reg [ADDR_W-1:0] ra_q;
    reg [1:0] rph_q;
    reg [8:0] bcnt_q;
    reg [`CKSUM_W-1:0] bsum_q;
    reg [ADDR_W-1:0] bstart_q;
    reg [2:0] tph_q;
    wire b_ready;
    wire [17:0] rd_word = mem[ra_q];
    reg [7:0] tx_byte;
    reg tx_valid;
    // bytes: header, 3 per sample, then count and checksum
    always @* begin
        tx_valid = 1'b0;
        tx_byte = 8'h00;
        if (st_q == S_READ) begin
            tx_valid = 1'b1;
            case (tph_q)
                3'h0: tx_byte = `BLK_HDR;
                3'h1: tx_byte = (rph_q == 2'h0) ? rd_word[7:0] :
                    (rph_q == 2'h1) ? rd_word[15:8] : {6'h00, rd_word[17:16]};
                3'h2: tx_byte = bcnt_q[7:0];
                3'h3: tx_byte = bsum_q[7:0];
                3'h4: tx_byte = bsum_q[15:8];
                default: tx_valid = 1'b0;
            endcase
        end
    end
    wire take = tx_valid && b_ready;

    // main state machine
    always @(posedge ref_clk) begin
        if (rst) begin
            st_q <= S_IDLE;
            wa_q <= {ADDR_W{1'b0}};
            cnt_q <= {(ADDR_W+1){1'b0}};
            stop_q <= 1'b0;
            prev_q <= 18'h0;
            trig_addr <= {ADDR_W{1'b0}};
            ra_q <= {ADDR_W{1'b0}};
            rph_q <= 2'h0;
            bcnt_q <= 9'h0;
            bsum_q <= {`CKSUM_W{1'b0}};
            bstart_q <= {ADDR_W{1'b0}};
            tph_q <= 3'h0;
            progress <= {ADDR_W{1'b0}};
        end else begin
            if (tick)
                prev_q <= chan;
            if (stop_cmd && st_q == S_PRE)
                stop_q <= 1'b1;
            case (st_q)
                S_IDLE: begin
                    stop_q <= 1'b0;
                    cnt_q <= {(ADDR_W+1){1'b0}};
                    if (run_cmd)
                        st_q <= S_PRE;
                end
                S_PRE: begin
                    if (tick) begin
                        mem[wa_q] <= chan;
                        wa_q <= wa_q + 1'b1;
                        // fill first, then wait trigger or stop
                        if (cnt_q != DEPTH)
                            cnt_q <= cnt_q + 1'b1;
                        else if (trig_now || stop_q || stop_cmd) begin
                            // go to posttrigger, mark trigger point
                            trig_addr <= wa_q;
                            cnt_q <= {(ADDR_W+1){1'b0}};
                            st_q <= S_POSTTRIGGER_STATE;
                        end
                    end
                end
                S_POSTTRIGGER_STATE: begin
                    if (tick) begin
                        mem[wa_q] <= chan;
                        wa_q <= wa_q + 1'b1;
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q + 1'b1 == posttrigger_state_len) begin
                            st_q <= S_READ;
                            ra_q <= wa_q + 1'b1;
                            bstart_q <= wa_q + 1'b1;
                            cnt_q <= {(ADDR_W+1){1'b0}};
                            tph_q <= 3'h0;
                            rph_q <= 2'h0;
                            bcnt_q <= 9'h0;
                            bsum_q <= {`CKSUM_W{1'b0}};
                        end
                    end
                end
                S_READ: begin
                    if (take) begin
                        case (tph_q)
                            3'h0: tph_q <= 3'h1;
                            3'h1: begin
                                bsum_q <= bsum_q + {8'h00, tx_byte};
                                if (rph_q == 2'h2) begin
                                    rph_q <= 2'h0;
                                    ra_q <= ra_q + 1'b1;
                                    bcnt_q <= bcnt_q + 1'b1;
                                    if (bcnt_q + 1'b1 == `BLOCK_LEN)
                                        tph_q <= 3'h2;
                                end else begin
                                    rph_q <= rph_q + 1'b1;
                                end
                            end
                            3'h2: tph_q <= 3'h3;
                            3'h3: tph_q <= 3'h4;
                            default: tph_q <= 3'h5;
                        endcase
                    end
                    if (tph_q == 3'h5) begin
                        tph_q <= 3'h0;
                        bcnt_q <= 9'h0;
                        bsum_q <= {`CKSUM_W{1'b0}};
                        if (block_nak) begin
                            ra_q <= bstart_q;
                        end else begin
                            bstart_q <= ra_q;
                            progress <= progress + BLK[ADDR_W-1:0];
                            cnt_q <= cnt_q + BLK;
                            if (cnt_q + BLK == DEPTH) begin
                                st_q <= S_IDLE;
                                progress <= {ADDR_W{1'b0}};
                            end
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // state report, live levels while idle
    always @(posedge ref_clk) begin
        if (rst) begin
            state_out <= S_IDLE;
            live_level <= 18'h0;
        end else begin
            state_out <= st_q;
            if (st_q == S_IDLE)
                live_level <= chan;
        end
    end

    // checksum readback, 16 bits shifted on serial data out
    // four clocks per bit so the synchronised data is settled at the falling edge
    reg [4:0] ckn_q;
    reg [1:0] cph_q;
    always @(posedge ref_clk) begin
        if (rst) begin
            ckn_q <= 5'h0;
            cph_q <= 2'h0;
            cksum_clk <= 1'b0;
            cksum_read <= 16'h0000;
            cksum_done <= 1'b0;
        end else begin
            cksum_done <= 1'b0;
            if (ckn_q == 5'h0) begin
                if (cksum_cmd) begin
                    ckn_q <= 5'h10;
                    cph_q <= 2'h0;
                end
            end else begin
                cph_q <= cph_q + 2'h1;
                cksum_clk <= ~cph_q[1];
                if (cph_q == 2'h2) begin
                    cksum_read <= {cksum_read[14:0], sdo_s_q};
                    ckn_q <= ckn_q - 5'h1;
                    cksum_done <= (ckn_q == 5'h1);
                end
            end
        end
    end

    // uart transmitter fed from the buffer
    wire [7:0] b_data;
    wire b_valid;
    reg [9:0] sh_q;
    reg [3:0] bit_q;
    reg [15:0] baud_q;
    // idle only once the stop bit has had its full length
    wire tx_idle = (bit_q == 4'h0) && (baud_q == 16'h0);
    word_buffer #(.W(8)) u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_data(tx_byte),
        .in_valid(tx_valid),
        .in_ready(b_ready),
        .out_data(b_data),
        .out_valid(b_valid),
        .out_ready(tx_idle)
    );
    always @(posedge ref_clk) begin
        if (rst) begin
            sh_q <= 10'h3ff;
            bit_q <= 4'h0;
            baud_q <= 16'h0;
            tx_line <= 1'b1;
        end else if (tx_idle) begin
            tx_line <= 1'b1;
            if (b_valid) begin
                sh_q <= {1'b1, b_data, 1'b0};
                bit_q <= 4'ha;
                baud_q <= 16'h0;
            end
        end else if (baud_q == 16'h0) begin
            tx_line <= sh_q[0];
            sh_q <= {1'b1, sh_q[9:1]};
            baud_q <= BAUD_DIV[15:0] - 16'h1;
            bit_q <= bit_q - 4'h1;
        end else begin
            baud_q <= baud_q - 16'h1;
        end
    end
endmodule

// File: design/la_capture_defs.vh
// Summary of operation
// - every channel keeps 64K samples in the capture buffer, which is uploaded over the serial link after capture.
// - sampling runs on the 10 MHz clock divided by rate_div+1 (about 153 Hz to 10 MHz) or on the external sample clock up to 5 MHz.
// - the trigger position splits the buffer 25/75, 50/50 or 75/25 between pre and posttrigger_state trigger samples.
// - each channel's trigger condition is ignore, low, high, rising, falling or either edge.
// - the trigger fires only when all 18 channel conditions hold in the same sample.
// - after run, a full 64K samples are taken first, then sampling goes on until trigger or stop.
// - while waiting for the trigger the pretrigger status is reported.
// - after trigger or stop the posttrigger state samples until the posttrigger count is reached.
// - after posttrigger the buffer is uploaded with progress reported.
// - while idle the live level of all 18 channels is available.
// - a probe assignment switches the matching analyzer input to the probe connector signal.
// - the design checksum is read back over the serial data out probe line; all zero means mismatch or open line.
// - upload goes in blocks with checksum and sample count, and a bad block is resent.
// - the serial link runs at 115,200 baud by default.
`ifndef LA_CAPTURE_DEFS_VH
`define LA_CAPTURE_DEFS_VH
`define CLK_HZ 10000000
`define BAUD_RATE 115200
`define BAUD_DIV ((`CLK_HZ + `BAUD_RATE / 2) / `BAUD_RATE)
`define NUM_CH 18
`define ADDR_W 16
`define BLOCK_LEN 256
`define CKSUM_W 16
`define TRIG_IGNORE 3'h0
`define TRIG_LOW 3'h1
`define TRIG_HIGH 3'h2
`define TRIG_RISE 3'h3
`define TRIG_FALL 3'h4
`define TRIG_EDGE 3'h5
`define POS_25 2'h0
`define POS_50 2'h1
`define POS_75 2'h2
`define BLK_HDR 8'ha5
`endif

// File: design/word_buffer.v
`timescale 1ns/1ps
// two-entry buffer, keeps a word when the receiver stalls
module word_buffer #(
    parameter W = 8
) (
    input wire ref_clk,
    input wire rst,
    input wire [W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [W-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [W-1:0] mem_q [0:1];
    reg wr_q;
    reg rd_q;
    reg [1:0] cnt_q;
    wire push = in_valid && (cnt_q != 2'h2);
    wire pop = out_ready && (cnt_q != 2'h0);

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];

    // pointers and fill count
    always @(posedge ref_clk) begin
        if (rst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop)
                rd_q <= ~rd_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// File: verif/la_capture_chk.sv
`timescale 1ns/1ps
// watches the capture engine at its top ports
module la_capture_chk #(
    parameter ADDR_W = 16
) (
    input wire ref_clk,
    input wire rst,
    input wire run_cmd,
    input wire [1:0] trig_pos,
    input wire cksum_cmd,
    input wire [1:0] state_out,
    input wire [17:0] live_level,
    input wire cksum_done,
    input wire tx_line
);
    localparam int DEPTH = 1 << ADDR_W;
    logic [31:0] pre_q, pre_d, posttrigger_state_q, posttrigger_state_d, need;
    // cycles spent in pre and in posttrigger_state, and the posttrigger_state count asked for
    assign pre_d = (state_out == 2'h1) ? pre_q + 32'h1 : 32'h0;
    assign posttrigger_state_d = (state_out == 2'h2) ? posttrigger_state_q + 32'h1 : 32'h0;
    assign need = (trig_pos == 2'h0) ? DEPTH * 3 / 4 : (trig_pos == 2'h1) ? DEPTH / 2 : DEPTH / 4;
    // counters restart on reset
    always @(posedge ref_clk) begin
        pre_q <= rst ? 32'h0 : pre_d;
        posttrigger_state_q <= rst ? 32'h0 : posttrigger_state_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_run;
        state_out == 2'h0 && run_cmd |-> ##[1:3] state_out == 2'h1;
    endproperty
    a_run: assert property (p_run) else $error("run not taken");
    property p_order;
        state_out != $past(state_out) |-> state_out == 2'h0 || state_out == $past(state_out) + 2'h1;
    endproperty
    a_order: assert property (p_order) else $error("bad state order");
    property p_pre_min;
        state_out == 2'h2 && $past(state_out) == 2'h1 |-> pre_q >= DEPTH;
    endproperty
    a_pre_min: assert property (p_pre_min) else $error("pre too short");
    property p_posttrigger_state_min;
        state_out == 2'h3 && $past(state_out) == 2'h2 |-> posttrigger_state_q + 32'h1 >= need;
    endproperty
    a_posttrigger_state_min: assert property (p_posttrigger_state_min) else $error("posttrigger_state too short");
    property p_live_idle;
        state_out != 2'h0 && $past(state_out) != 2'h0 |-> $stable(live_level);
    endproperty
    a_live_idle: assert property (p_live_idle) else $error("live moved");
    property p_tx_quiet;
        state_out == 2'h1 || state_out == 2'h2 |-> tx_line;
    endproperty
    a_tx_quiet: assert property (p_tx_quiet) else $error("tx busy in capture");
    property p_read_tx;
        state_out == 2'h3 && $past(state_out) == 2'h2 |-> ##[0:60] !tx_line;
    endproperty
    a_read_tx: assert property (p_read_tx) else $error("no upload start");
    property p_done_pulse;
        cksum_done |=> !cksum_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_cksum_time;
        cksum_cmd && state_out == 2'h0 |-> ##[16:200] cksum_done;
    endproperty
    a_cksum_time: assert property (p_cksum_time) else $error("no checksum");
endmodule

// File: verif/la_host_model.sv
`timescale 1ns/1ps
// host serial receiver and target checksum source
module la_host_model #(
    parameter BAUD_DIV = 3,
    parameter CKSUM = 16'h3c5a
) (
    input wire ref_clk,
    input wire tx_line,
    input wire cksum_cmd,
    input wire cksum_clk,
    output logic serial_data_out,
    output logic [7:0] rx_byte,
    output int rx_cnt
);
    initial begin
        rx_cnt = 0;
        rx_byte = 8'h00;
        forever begin
            @(negedge tx_line);
            repeat (BAUD_DIV + BAUD_DIV / 2) @(posedge ref_clk);
            for (int j = 0; j < 8; j++) begin
                rx_byte[j] = tx_line;
                repeat (BAUD_DIV) @(posedge ref_clk);
            end
            rx_cnt++;
        end
    end
    initial begin
        serial_data_out = 1'b1;
        forever begin
            @(posedge ref_clk);
            if (cksum_cmd) begin
                for (int i = 15; i >= 0; i--) begin
                    serial_data_out = CKSUM[i];
                    @(posedge cksum_clk);
                    @(negedge cksum_clk);
                end
                serial_data_out = ~CKSUM[0];  // line released
            end
        end
    end
endmodule

// File: verif/logic_analyzer_capture_bench.sv
`timescale 1ns/1ps
`include "la_capture_defs.vh"
// self-checking bench for the capture engine
module logic_analyzer_capture_bench;
    localparam int DEPTH = 256;
    localparam logic [15:0] CK = 16'h3c5a;
    localparam logic [17:0] SMP = 18'h2a5c3;
    localparam logic [2:0] RC [7] = '{`TRIG_IGNORE, `TRIG_LOW, `TRIG_HIGH, `TRIG_RISE,
        `TRIG_FALL, `TRIG_EDGE, `TRIG_RISE};
    localparam logic [17:0] RB [7] = '{18'h0, 18'hc, 18'h8, 18'h8, 18'hc, 18'h8, 18'h0};
    localparam logic [17:0] RA [7] = '{18'h8, 18'h8, 18'hc, 18'hc, 18'h8, 18'hc, 18'h4};
    localparam logic [1:0] RF [7] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1};
    logic ref_clk, rst, external_sample_clock, sync_mode, run_cmd, stop_cmd;
    logic probe_sel_a, probe_sel_b, probe_out_a, probe_out_b, cksum_cmd, block_nak;
    logic [17:0] target_in;
    logic [15:0] rate_div;
    logic [1:0] trig_pos;
    logic [53:0] trig_cond;
    wire serial_data_out, cksum_done, cksum_clk, tx_line;
    wire [1:0] state_out;
    wire [17:0] live_level;
    wire [7:0] trig_addr, progress, rx_byte;
    wire [15:0] cksum_read;
    int rx_cnt, num_errors, cmp_count, cyc, n;
    logic_analyzer_capture #(.ADDR_W(8), .BAUD_DIV(3)) i_dut (.*);
    la_host_model #(.BAUD_DIV(3), .CKSUM(CK)) i_host (.*);
    // clock and a slower free-running target clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        external_sample_clock = 1'b0;
        forever #115 external_sample_clock = ~external_sample_clock;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic do_rst;
        rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
    endtask
    task automatic pulse_run;
        run_cmd = 1'b1;
        @(negedge ref_clk);
        run_cmd = 1'b0;
    endtask
    task automatic wait_st(input logic [1:0] exp, input int max);
        int k;
        k = 0;
        while (state_out !== exp && k < max) begin
            @(negedge ref_clk);
            k++;
        end
        cmp(state_out, exp);
    endtask
    task automatic get_byte(output logic [7:0] b);
        int k, c;
        c = rx_cnt;
        k = 0;
        while (rx_cnt == c && k < 100) begin
            @(negedge ref_clk);
            k++;
        end
        b = rx_byte;
    endtask
    // one block: header, samples in three bytes, count, sum
    task automatic get_blk;
        logic [7:0] b, e;
        logic [15:0] s;
        s = 16'h0;
        get_byte(b);
        cmp(b, `BLK_HDR);
        for (int i = 0; i < 3 * `BLOCK_LEN; i++) begin
            get_byte(b);
            e = (i % 3 == 0) ? SMP[7:0] : (i % 3 == 1) ? SMP[15:8] : {6'h0, SMP[17:16]};
            s = s + {8'h0, e};
            cmp(b, e);
        end
        get_byte(b);
        cmp(b, 8'h00);
        get_byte(b);
        cmp(b, s[7:0]);
        get_byte(b);
        cmp(b, s[15:8]);
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            end_of_test;
        end
    end
    initial begin
        {rst, sync_mode, run_cmd, stop_cmd, probe_sel_a, probe_sel_b} = 6'h20;
        {probe_out_a, probe_out_b, cksum_cmd, block_nak} = 4'h0;
        {target_in, rate_div, trig_pos, trig_cond} = {SMP, 72'h0};
        {num_errors, cmp_count, cyc} = 96'h0;
        do_rst;
        cmp(state_out, 2'h0);
        cmp(tx_line, 1'b1);
        repeat (5) @(negedge ref_clk);
        cmp(live_level, SMP);
        {probe_sel_a, probe_sel_b} = 2'h3;
        repeat (5) @(negedge ref_clk);
        cmp(live_level, {SMP[17:2], 2'h0});
        {probe_sel_a, probe_sel_b} = 2'h0;
        // trigger rows, channel 3 must also be high
        for (int k = 0; k < 7; k++) begin
            trig_cond = (54'(RC[k]) << 6) | (54'(`TRIG_HIGH) << 9);
            target_in = RB[k];
            pulse_run;
            repeat (DEPTH + 40) @(negedge ref_clk);
            cmp(state_out, 2'h1);
            target_in = RA[k];
            repeat (10) @(negedge ref_clk);
            cmp(state_out, RF[k]);
            do_rst;
        end
        // stop ends pre; posttrigger_state length per position at half rate
        rate_div = 16'h1;
        trig_cond = 54'(`TRIG_HIGH) << 9;
        target_in = 18'h0;
        for (int p = 0; p < 3; p++) begin
            trig_pos = 2'(p);
            pulse_run;
            repeat (2 * DEPTH + 20) @(negedge ref_clk);
            stop_cmd = 1'b1;
            @(negedge ref_clk);
            stop_cmd = 1'b0;
            wait_st(2'h2, 20);
            for (n = 0; state_out === 2'h2 && n < 4 * DEPTH; n++)
                @(negedge ref_clk);
            cmp(n >= DEPTH * (3 - p) / 2 - 2 && n <= DEPTH * (3 - p) / 2 + 8, 1'b1);
            do_rst;
        end
        rate_div = 16'h0;
        sync_mode = 1'b1;
        trig_cond = 54'h0;
        pulse_run;
        repeat (DEPTH + 100) @(negedge ref_clk);
        cmp(state_out, 2'h1);
        wait_st(2'h2, 400);
        do_rst;
        sync_mode = 1'b0;
        cksum_cmd = 1'b1;
        @(negedge ref_clk);
        cksum_cmd = 1'b0;
        for (n = 0; cksum_done !== 1'b1 && n < 300; n++)
            @(negedge ref_clk);
        cmp(cksum_read, CK);
        // full upload, first block refused once
        target_in = SMP;
        trig_pos = 2'h2;
        block_nak = 1'b1;
        pulse_run;
        wait_st(2'h3, 2 * DEPTH);
        cmp(trig_addr, 8'h00);
        get_blk;
        block_nak = 1'b0;
        get_blk;
        wait_st(2'h0, 500);
        cmp(progress, 8'h00);
        pulse_run;
        wait_st(2'h1, 4);
        end_of_test;
    end
endmodule
bind logic_analyzer_capture la_capture_chk #(.ADDR_W(ADDR_W)) i_chk (.ref_clk(ref_clk),
    .rst(rst), .run_cmd(run_cmd), .trig_pos(trig_pos), .cksum_cmd(cksum_cmd),
    .state_out(state_out), .live_level(live_level), .cksum_done(cksum_done), .tx_line(tx_line));
